// [hw/startup_mode_pin_function_select.sv]
// start-up mode capture, boot sequencing and multifunction pin control
`timescale 1ns/1ps
`include "sms_params.svh"
module startup_mode_pin_function_select (
    // clocks and power-on reset
    input  wire logic              clk_sys,
    input  wire logic              ser_clk,
    input  wire logic              rst_b,
    // power-down and mode pins
    input  wire logic              power_down_n,
    input  wire logic [1:0]        startup_mode_select,
    // status pins: sensed level, drive value, drive enable
    input  wire logic [1:0]        monitor_out_0_lvl,
    input  wire logic [1:0]        monitor_out_1_lvl,
    output logic                   monitor_out_0_o,
    output logic                   monitor_out_0_oe,
    output logic                   monitor_out_1_o,
    output logic                   monitor_out_1_oe,
    // multifunction pins
    input  wire logic              mf_pin0_out_sync_n,
    input  wire logic              mf_pin1_chip_select,
    input  wire logic              mf_pin2_serial_out_i,
    output logic                   mf_pin2_serial_out_o,
    output logic                   mf_pin2_serial_out_oe,
    input  wire logic              mf_pin3_freq_up_a,
    input  wire logic              mf_pin4_freq_down_a,
    input  wire logic              mf_pin5_freq_up_b_i,
    output logic                   mf_pin5_freq_up_b_o,
    output logic                   mf_pin5_freq_up_b_oe,
    input  wire logic              mf_pin6_freq_down_b_i,
    output logic                   mf_pin6_freq_down_b_o,
    output logic                   mf_pin6_freq_down_b_oe,
    // manual reference select pins
    input  wire logic [1:0]        ref_sel_loop_a,
    input  wire logic [1:0]        ref_sel_loop_b,
    // configuration from device registers
    input  wire logic [3:0][2:0]   mon_sel,
    input  wire logic [3:0]        mon_od,
    input  wire logic [3:0]        mon_pol,
    input  wire logic [7:0]        status_src,
    input  wire logic              dco_step_en_a,
    input  wire logic              dco_step_en_b,
    input  wire logic              mf56_status,
    input  wire logic              rom_pins_fn_en,
    // register loader handshake
    output logic                   load_start,
    output logic                   load_from_rom,
    output logic [3:0]             load_page,
    input  wire logic              load_done,
    // serial host port control
    output logic                   i2c_enable,
    output logic                   spi_enable,
    output logic [6:0]             i2c_addr,
    output logic                   spi_chip_sel_n,
    output logic                   host_grant,
    input  wire logic              spi_sdo,
    input  wire logic              spi_sdo_oe,
    // loop channel controls
    output logic [1:0]             ref_input_sel_a,
    output logic [1:0]             ref_input_sel_b,
    output logic                   out_sync_n,
    output logic                   freq_up_a,
    output logic                   freq_down_a,
    output logic                   freq_up_b,
    output logic                   freq_down_b,
    // block state
    output sms_pkg::startup_mode_t startup_mode,
    output logic                   boot_done
);
    typedef struct packed {
        sms_pkg::boot_state_t   state;
        sms_pkg::startup_mode_t mode;
        logic [1:0]             addr_lsb;
        logic [3:0]             page;
        logic                   pdn_prev;
        logic                   load_start;
        logic [3:0]             step_prev;
        logic [3:0]             step_pulse;
        logic                   sync_req;
        logic                   cs_n;
        logic [1:0]             ref_a;
        logic [1:0]             ref_b;
        logic [3:0]             mon_o;
        logic [3:0]             mon_oe;
        logic                   i2c_en;
        logic                   spi_en;
        logic [6:0]             addr;
    } core_t;

    core_t                       r;
    core_t                       next_r;
    logic [`SMS_NUM_PINS-1:0]    pins_raw;
    logic [`SMS_NUM_PINS-1:0]    pins;
    logic                        pdn_s;
    logic [1:0]                  mode_lvl;
    logic [1:0]                  st0_lvl;
    logic [1:0]                  st1_lvl;
    logic [6:0]                  mf_in;
    logic [1:0]                  ref_a_pin;
    logic [1:0]                  ref_b_pin;
    logic                        pdn_rise;
    logic                        rom_mode;
    logic                        fn_36;
    logic                        as_status56;
    logic [3:0]                  step_gate;
    logic [3:0]                  mon_en;
    logic [3:0]                  mon_val;
    sms_pkg::startup_mode_t      dec_mode;

    // every pin crosses into clk_sys through three stages
    assign pins_raw = {
        power_down_n,
        startup_mode_select,
        monitor_out_0_lvl,
        monitor_out_1_lvl,
        mf_pin6_freq_down_b_i,
        mf_pin5_freq_up_b_i,
        mf_pin4_freq_down_a,
        mf_pin3_freq_up_a,
        mf_pin2_serial_out_i,
        mf_pin1_chip_select,
        mf_pin0_out_sync_n,
        ref_sel_loop_a,
        ref_sel_loop_b
    };

    pin_sync #(.W(`SMS_NUM_PINS), .RST(`SMS_PIN_RST)) u_pins (
        .clk   (clk_sys),
        .rst_b (rst_b),
        .d     (pins_raw),
        .q     (pins)
    );

    // unpack settled pins
    assign pdn_s     = pins[17];
    assign mode_lvl  = pins[16:15];
    assign st0_lvl   = pins[14:13];
    assign st1_lvl   = pins[12:11];
    assign mf_in     = pins[10:4];
    assign ref_a_pin = pins[3:2];
    assign ref_b_pin = pins[1:0];

    // start-up point is the settled power-down release
    assign pdn_rise = pdn_s & ~r.pdn_prev; // R13

    // three-level mode decode; SPI needs all three pins at mid
    always_comb begin
        if (mode_lvl == `SMS_LVL_HIGH) begin
            dec_mode = sms_pkg::MODE_ROM_I2C; // R4
        end else if (mode_lvl == `SMS_LVL_MID && st0_lvl == `SMS_LVL_MID
                     && st1_lvl == `SMS_LVL_MID) begin
            dec_mode = sms_pkg::MODE_EE_SPI; // R4 R13
        end else begin
            dec_mode = sms_pkg::MODE_EE_I2C; // R4
        end
    end

    // pin function selection from the captured mode
    assign rom_mode    = (r.mode == sms_pkg::MODE_ROM_I2C);
    assign fn_36       = ~rom_mode | rom_pins_fn_en; // R12
    assign as_status56 = (rom_mode & ~rom_pins_fn_en) | mf56_status; // R10 R12

    // step inputs: bits 0..3 are pins 3..6
    assign step_gate[0] = fn_36 & dco_step_en_a; // R9
    assign step_gate[1] = fn_36 & dco_step_en_a; // R9
    assign step_gate[2] = fn_36 & ~as_status56 & dco_step_en_b; // R10
    assign step_gate[3] = fn_36 & ~as_status56 & dco_step_en_b; // R10

    // status channels: 0,1 dedicated pins, 2,3 pins 5 and 6
    genvar c;
    generate
        for (c = 0; c < `SMS_NUM_MON; c++) begin : g_mon
            if (c < 2) begin : g_ded
                assign mon_en[c] = 1'b1; // R14
            end else begin : g_mf
                assign mon_en[c] = as_status56; // R10 R12
            end
            assign mon_val[c] = status_src[mon_sel[c]] ^ mon_pol[c]; // R3
        end
    endgenerate

    // boot sequencer and pin function logic
    always_comb begin
        next_r            = r;
        next_r.pdn_prev   = pdn_s;
        next_r.load_start = 1'b0;
        next_r.step_pulse = 4'h0;
        case (r.state)
            sms_pkg::ST_HOLD: begin
                if (pdn_rise) begin
                    // captured once here and held until next start-up
                    next_r.mode       = dec_mode; // R5 R18
                    next_r.addr_lsb   = mf_in[2:1]; // R7 R18
                    next_r.page       = mf_in[3:0]; // R11 R18
                    next_r.load_start = 1'b1;
                    next_r.state      = sms_pkg::ST_LOAD;
                end
            end
            sms_pkg::ST_LOAD: begin
                // serial port stays closed until the loader reports done
                if (load_done) begin
                    next_r.state  = sms_pkg::ST_RUN; // R19
                    next_r.i2c_en = (r.mode != sms_pkg::MODE_EE_SPI); // R15
                    next_r.spi_en = (r.mode == sms_pkg::MODE_EE_SPI); // R6 R15
                    if (r.mode == sms_pkg::MODE_ROM_I2C) begin
                        next_r.addr = {`SMS_ADDR_UPPER, `SMS_ROM_ADDR_LSB}; // R17
                    end else begin
                        next_r.addr = {`SMS_ADDR_UPPER, r.addr_lsb}; // R7 R17
                    end
                end
            end
            sms_pkg::ST_RUN: begin
                next_r.ref_a     = ref_a_pin; // R1
                next_r.ref_b     = ref_b_pin; // R2
                next_r.sync_req  = ~rom_mode & ~mf_in[0]; // R8
                next_r.cs_n      = ~r.spi_en | mf_in[1]; // R6
                next_r.step_prev = mf_in[6:3];
                // one pulse per rising edge on an enabled step pin
                next_r.step_pulse = mf_in[6:3] & ~r.step_prev & step_gate; // R9 R10
                for (int i = 0; i < `SMS_NUM_MON; i++) begin
                    // open-drain pulls low only, push-pull drives both ways
                    next_r.mon_o[i]  = ~mon_od[i] & mon_val[i]; // R3
                    next_r.mon_oe[i] = mon_en[i] & (~mon_od[i] | ~mon_val[i]); // R3 R14
                end
            end
            default: begin
                next_r.state = sms_pkg::ST_HOLD;
            end
        endcase
        // power-down low clears all but the captured start-up latches
        if (!pdn_s) begin
            next_r          = '0; // R16
            next_r.mode     = r.mode; // R18
            next_r.addr_lsb = r.addr_lsb; // R18
            next_r.page     = r.page; // R18
            next_r.state    = sms_pkg::ST_HOLD; // R16
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // serial clock side: access gate and SPI data out pin
    link_gate u_link (
        .ser_clk    (ser_clk),
        .rst_b      (rst_b),
        .host_en    (r.i2c_en | r.spi_en),
        .spi_mode   (r.spi_en),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .host_grant (host_grant),
        .sdo_o      (mf_pin2_serial_out_o),
        .sdo_oe     (mf_pin2_serial_out_oe)
    );

    // loader handshake
    assign load_start    = r.load_start;
    assign load_from_rom = rom_mode; // R11
    assign load_page     = r.page; // R11

    // serial host port
    assign i2c_enable     = r.i2c_en;
    assign spi_enable     = r.spi_en;
    assign i2c_addr       = r.addr;
    assign spi_chip_sel_n = ~r.spi_en | r.cs_n;

    // loop controls
    assign ref_input_sel_a = r.ref_a;
    assign ref_input_sel_b = r.ref_b;
    assign out_sync_n      = ~r.sync_req;
    assign freq_up_a       = r.step_pulse[0];
    assign freq_down_a     = r.step_pulse[1];
    assign freq_up_b       = r.step_pulse[2];
    assign freq_down_b     = r.step_pulse[3];

    // pin drivers; off while sensing the mode levels
    assign monitor_out_0_o        = r.mon_o[0];
    assign monitor_out_0_oe       = r.mon_oe[0];
    assign monitor_out_1_o        = r.mon_o[1];
    assign monitor_out_1_oe       = r.mon_oe[1];
    assign mf_pin5_freq_up_b_o    = r.mon_o[2];
    assign mf_pin5_freq_up_b_oe   = r.mon_oe[2];
    assign mf_pin6_freq_down_b_o  = r.mon_o[3];
    assign mf_pin6_freq_down_b_oe = r.mon_oe[3];

    // block state
    assign startup_mode = r.mode;
    assign boot_done    = (r.state == sms_pkg::ST_RUN);
endmodule

// [hw/sms_params.svh]
// constants for the start-up mode and multifunction pin block
//
// Contract
// (R1) loop a reference select pins 00b..11b choose ref input 0..3
// (R2) loop b reference select pins use the same 00b..11b encoding
// (R3) each status output has selectable source, push-pull/open-drain and polarity
// (R4) mode level low: EEPROM+I2C, mid: EEPROM+SPI, high: ROM+I2C
// (R5) mode and address/page pins captured only at power-on, later changes ignored
// (R6) SPI mode: pin 1 is chip select, pin 2 is serial data out
// (R7) low mode: pins 2 and 1 give the two low I2C address bits
// (R8) EEPROM modes: pin 0 is active-low output sync, tied high if unused
// (R9) EEPROM modes: pins 4/3 step loop a oscillator down/up when enabled
// (R10) EEPROM modes: pins 6/5 step loop b or act as status outputs
// (R11) high mode: pins 3..0 at reset pick one of sixteen ROM pages
// (R12) ROM mode: pins 6/5 status, pin 4 ignored; register enable restores functions
// (R13) mode and both status pins sampled three-level at power-down release
// (R14) after power-up the status pins become driven outputs
// (R15) host uses only the serial port chosen by the start-up mode
// (R16) power-down low holds everything in reset; release restarts from initial state; code keeps the captured mode, address and page
// (R17) upper address bits are 11000b; ROM mode low address bits are 00b
// (R18) captured mode, address and page change only at the next start-up
// (R19) register load finishes before the serial port accepts access
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// three-level pin codes as delivered by the level sensing front end
`define SMS_LVL_LOW       2'h0
`define SMS_LVL_MID       2'h1
`define SMS_LVL_HIGH      2'h2

// i2c address parts
`define SMS_ADDR_UPPER    5'h18
`define SMS_ROM_ADDR_LSB  2'h0

// sizes and reset values
`define SMS_NUM_PINS      18
`define SMS_PIN_RST       18'h00000
`define SMS_LINK_RST      2'h0
`define SMS_NUM_MON       4

`endif

// [hw/sms_pkg.sv]
// types shared by the start-up mode and multifunction pin block
package sms_pkg;

    // start-up mode decoded at power-down release
    typedef enum logic [1:0] {
        MODE_EE_I2C,
        MODE_EE_SPI,
        MODE_ROM_I2C
    } startup_mode_t;

    // boot sequencer states
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LOAD,
        ST_RUN
    } boot_state_t;

endpackage

// [hw/pin_sync.sv]
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int              W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    // asynchronous pins and their settled value
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_t;

    sync_t r;
    sync_t next_r;

    // s1 feeds only s2; a bit moves once s2 and s3 agree
    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.q  = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '{s1: RST, s2: RST, s3: RST, q: RST};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;
endmodule

// [hw/link_gate.sv]
// serial-clock side: host access gate and SPI data out pin driver
`timescale 1ns/1ps
`include "sms_params.svh"
module link_gate (
    // serial link clock and reset
    input  wire logic  ser_clk,
    input  wire logic  rst_b,
    // levels from the system domain
    input  wire logic  host_en,
    input  wire logic  spi_mode,
    // serial core data out
    input  wire logic  spi_sdo,
    input  wire logic  spi_sdo_oe,
    // to serial core and pin
    output logic       host_grant,
    output logic       sdo_o,
    output logic       sdo_oe
);
    typedef struct packed {
        logic o;
        logic oe;
    } link_t;

    link_t       r;
    link_t       next_r;
    logic [1:0]  lvl;

    // levels cross with the same three-stage rule as pins
    pin_sync #(.W(2), .RST(`SMS_LINK_RST)) u_sync (
        .clk   (ser_clk),
        .rst_b (rst_b),
        .d     ({spi_mode, host_en}),
        .q     (lvl)
    );

    // pin 2 drives only in SPI mode once loading is done
    always_comb begin
        next_r    = r;
        next_r.o  = spi_sdo;
        next_r.oe = lvl[1] & lvl[0] & spi_sdo_oe; // R6 R19
    end

    // state register
    always_ff @(posedge ser_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign host_grant = lvl[0]; // R19
    assign sdo_o      = r.o;
    assign sdo_oe     = r.oe;
endmodule

// [verification/sms_monitor.sv]
// assertion checker for start-up capture, host port and pin functions
`timescale 1ns/1ps
`include "sms_params.svh"
module sms_monitor (
    // clock, reset and boot state
    input wire logic                   clk_sys,
    input wire logic                   rst_b,
    input wire logic                   boot_done,
    input wire logic                   load_done,
    input wire sms_pkg::startup_mode_t startup_mode,
    // host port
    input wire logic [6:0]             i2c_addr,
    input wire logic                   i2c_enable,
    input wire logic                   spi_enable,
    input wire logic                   spi_chip_sel_n,
    input wire logic                   mf_pin2_serial_out_oe,
    // pins and configuration
    input wire logic [1:0]             ref_sel_loop_a,
    input wire logic [1:0]             ref_sel_loop_b,
    input wire logic [1:0]             ref_input_sel_a,
    input wire logic [1:0]             ref_input_sel_b,
    input wire logic [3:0][2:0]        mon_sel,
    input wire logic [3:0]             mon_od,
    input wire logic [3:0]             mon_pol,
    input wire logic [7:0]             status_src,
    input wire logic                   monitor_out_0_o,
    input wire logic                   monitor_out_0_oe,
    input wire logic                   monitor_out_1_oe,
    input wire logic                   dco_step_en_a,
    input wire logic                   freq_up_a
);
    logic exp0;

    // live expectation; the property waits for the config to hold still
    assign exp0 = status_src[mon_sel[0]] ^ mon_pol[0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_UPPER_ADDR: assert property (boot_done |-> i2c_addr[6:2] == `SMS_ADDR_UPPER)
        else $error("upper i2c address bits wrong");
    AST_ROM_LSB: assert property (boot_done && startup_mode == sms_pkg::MODE_ROM_I2C
        |-> i2c_addr[1:0] == `SMS_ROM_ADDR_LSB) else $error("rom mode address low bits wrong");
    AST_PORT_SEL: assert property (boot_done |-> (i2c_enable != spi_enable)
        && (spi_enable == (startup_mode == sms_pkg::MODE_EE_SPI))) else $error("port select");
    AST_LOAD_FIRST: assert property ($rose(boot_done) |-> $past(load_done))
        else $error("boot finished without loader done");
    AST_CAPTURE_HELD: assert property (boot_done && $past(boot_done)
        |-> $stable(i2c_addr) && $stable(startup_mode)) else $error("captured value moved");
    AST_REF_A: assert property ((boot_done && $stable(ref_sel_loop_a))[*8]
        |-> ref_input_sel_a == ref_sel_loop_a) else $error("loop a reference select wrong");
    AST_REF_B: assert property ((boot_done && $stable(ref_sel_loop_b))[*8]
        |-> ref_input_sel_b == ref_sel_loop_b) else $error("loop b reference select wrong");
    AST_MONITOR_OUT_0: assert property ((boot_done && $stable(mon_sel) && $stable(mon_od)
        && $stable(mon_pol) && $stable(status_src))[*3]
        |-> (mon_od[0] ? (!monitor_out_0_o && monitor_out_0_oe == !exp0)
                       : (monitor_out_0_oe && monitor_out_0_o == exp0)))
        else $error("status output 0 drive wrong");
    AST_STATUS_QUIET: assert property (!boot_done && !$past(boot_done)
        |-> !monitor_out_0_oe && !monitor_out_1_oe) else $error("status driven before run");
    AST_STEP_GATE: assert property (freq_up_a |-> $past(dco_step_en_a) ##1 !freq_up_a)
        else $error("step pulse ungated or too long");
    AST_SDO_SPI: assert property (mf_pin2_serial_out_oe
        |-> startup_mode == sms_pkg::MODE_EE_SPI) else $error("data out driven outside spi");
    AST_CS_SPI: assert property (!spi_chip_sel_n |-> spi_enable)
        else $error("chip select active outside spi");

    // main scenarios reached
    cover property ($rose(boot_done) && startup_mode == sms_pkg::MODE_ROM_I2C);
    cover property ($rose(boot_done) && startup_mode == sms_pkg::MODE_EE_SPI);
    cover property (freq_up_a);
endmodule

bind startup_mode_pin_function_select sms_monitor mon (.*);

// [verification/sms_loader_model.sv]
// register loader model answering a start request after a set delay
`timescale 1ns/1ps
module sms_loader_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // load handshake
    input  wire logic       load_start,
    input  wire logic [7:0] delay,
    output logic            load_done
);
    int cnt;

    // one done pulse per request; zero delay answers two cycles after the request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            load_done <= 1'b0;
        end else begin
            load_done <= (cnt == 1);
            if (load_start)
                cnt <= int'(delay) + 1;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// [verification/test_startup_mode_pin_function_select.sv]
// self-checking bench for start-up capture, host port and pin functions
`timescale 1ns/1ps
`include "sms_params.svh"
module test_startup_mode_pin_function_select;
    logic                   clk_sys, ser_clk, rst_b, power_down_n, mf56_status;
    logic [1:0]             startup_mode_select, monitor_out_0_lvl, monitor_out_1_lvl;
    logic [1:0]             ref_sel_loop_a, ref_sel_loop_b, ref_input_sel_a, ref_input_sel_b;
    logic                   monitor_out_0_o, monitor_out_0_oe, monitor_out_1_o;
    logic                   monitor_out_1_oe, mf_pin0_out_sync_n, mf_pin1_chip_select;
    logic                   mf_pin2_serial_out_i, mf_pin2_serial_out_o, mf_pin2_serial_out_oe;
    logic                   mf_pin3_freq_up_a, mf_pin4_freq_down_a, mf_pin5_freq_up_b_i;
    logic                   mf_pin5_freq_up_b_o, mf_pin5_freq_up_b_oe, mf_pin6_freq_down_b_i;
    logic                   mf_pin6_freq_down_b_o, mf_pin6_freq_down_b_oe;
    logic [3:0][2:0]        mon_sel;
    logic [3:0]             mon_od, mon_pol, load_page;
    logic [7:0]             status_src, delay;
    logic                   dco_step_en_a, dco_step_en_b, rom_pins_fn_en;
    logic                   load_start, load_from_rom, load_done, i2c_enable, spi_enable;
    logic [6:0]             i2c_addr;
    logic                   spi_chip_sel_n, host_grant, spi_sdo, spi_sdo_oe, out_sync_n;
    logic                   freq_up_a, freq_down_a, freq_up_b, freq_down_b, boot_done;
    sms_pkg::startup_mode_t startup_mode;
    int                     mismatches, checks, cycles, k;

    startup_mode_pin_function_select DUT (.*);
    sms_loader_model loader (.*);

    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // hang guard, well above the planned run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // link clock runs only inside a frame, 30 ns period, odd phase
    task automatic frame(input int n);
        #7;
        repeat (2 * n) #15 ser_clk = ~ser_clk;
        @(negedge clk_sys);
    endtask

    task automatic set_pins(input logic [6:0] p);
        {mf_pin6_freq_down_b_i, mf_pin5_freq_up_b_i, mf_pin4_freq_down_a, mf_pin3_freq_up_a,
         mf_pin2_serial_out_i, mf_pin1_chip_select, mf_pin0_out_sync_n} = p;
    endtask

    // one start-up in the given mode, then run-time pin checks
    task automatic boot(input logic [1:0] md, input logic [1:0] s0);
        int         m, i;
        int         cnt[4];
        logic [6:0] p;
        logic [7:0] mo;
        logic       v, ea, eb;
        p = 7'($urandom);
        m = (md == 2'h2) ? 2 : (md == 2'h1 && s0 == `SMS_LVL_MID) ? 1 : 0;
        power_down_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        frame(3);
        chk(boot_done, 0);
        chk(i2c_enable | spi_enable, 0);
        startup_mode_select = md;
        monitor_out_0_lvl = s0;
        monitor_out_1_lvl = `SMS_LVL_MID;
        set_pins(p);
        repeat (6) @(negedge clk_sys);
        power_down_n = 1'b1;
        repeat (12) @(negedge clk_sys);
        startup_mode_select = 2'($urandom);
        set_pins(7'($urandom));
        frame(8);
        if (delay != 8'h00)
            chk(host_grant, 0);
        for (i = 0; i < 200 && boot_done !== 1'b1; i++)
            @(negedge clk_sys);
        chk(boot_done, 1);
        chk(startup_mode, m);
        chk(spi_enable, m == 1);
        chk(i2c_enable, m != 1);
        chk(load_from_rom, m == 2);
        if (m == 2)
            chk(load_page, p[3:0]);
        if (m != 1)
            chk(i2c_addr, {`SMS_ADDR_UPPER, m == 0 ? p[2:1] : `SMS_ROM_ADDR_LSB});
        frame(8);
        chk(host_grant, 1);
        for (i = 0; i < 4; i++) begin
            ref_sel_loop_a = 2'(i);
            ref_sel_loop_b = 2'(3 - i);
            repeat (8) @(negedge clk_sys);
            chk(ref_input_sel_a, i);
            chk(ref_input_sel_b, 3 - i);
        end
        {dco_step_en_a, dco_step_en_b, rom_pins_fn_en, mf56_status} = 4'($urandom);
        {mon_sel, mon_od, mon_pol, status_src} = 28'($urandom);
        repeat (4) @(negedge clk_sys);
        mo = {mf_pin6_freq_down_b_o, mf_pin6_freq_down_b_oe, mf_pin5_freq_up_b_o,
              mf_pin5_freq_up_b_oe, monitor_out_1_o, monitor_out_1_oe, monitor_out_0_o,
              monitor_out_0_oe};
        eb = (m == 2 && !rom_pins_fn_en) || mf56_status;
        for (i = 0; i < 4; i++) begin
            v = status_src[mon_sel[i]] ^ mon_pol[i];
            chk(mo[i*2+:2], {!mon_od[i] && v, (i < 2 || eb) && !(mon_od[i] && v)});
        end
        // step pins need a clean rising edge, so park them low first
        ea = dco_step_en_a && (m != 2 || rom_pins_fn_en);
        eb = dco_step_en_b && !eb && (m != 2 || rom_pins_fn_en);
        set_pins(7'h01);
        repeat (6) @(negedge clk_sys);
        set_pins(7'h78);
        cnt = '{0, 0, 0, 0};
        repeat (10) begin
            @(negedge clk_sys);
            cnt[0] += freq_up_a;
            cnt[1] += freq_down_a;
            cnt[2] += freq_up_b;
            cnt[3] += freq_down_b;
        end
        chk(cnt[0], ea);
        chk(cnt[1], ea);
        chk(cnt[2], eb);
        chk(cnt[3], eb);
        chk(out_sync_n, m == 2);
        chk(spi_chip_sel_n, m != 1);
        spi_sdo = 1'($urandom);
        spi_sdo_oe = 1'b1;
        frame(3);
        chk(mf_pin2_serial_out_oe, m == 1);
        if (m == 1)
            chk(mf_pin2_serial_out_o, spi_sdo);
        spi_sdo_oe = 1'b0;
    endtask

    // main sequence
    initial begin
        ser_clk = 1'b0;
        rst_b = 1'b0;
        power_down_n = 1'b0;
        startup_mode_select = `SMS_LVL_LOW;
        monitor_out_0_lvl = `SMS_LVL_MID;
        monitor_out_1_lvl = `SMS_LVL_MID;
        set_pins(7'h01);
        {ref_sel_loop_a, ref_sel_loop_b, mon_sel, mon_od, mon_pol, status_src} = '0;
        {dco_step_en_a, dco_step_en_b, rom_pins_fn_en, mf56_status} = 4'h0;
        {spi_sdo, spi_sdo_oe, delay} = '0;
        {mismatches, checks, cycles} = '0;
        void'($urandom(32'h4911966E));
        repeat (3) @(negedge clk_sys);
        rst_b = 1'b1;
        chk(boot_done, 0);
        chk(host_grant, 0);
        for (k = 0; k < 8; k++) begin
            delay = (k % 2) ? 8'h3C : 8'h00;
            boot(2'(k), (k == 5) ? `SMS_LVL_LOW : `SMS_LVL_MID);
        end
        summarize();
    end
endmodule
